/* rtl/i2c_bus_controller_timing.sv */
`timescale 1ns/100ps
`include "i2c_timing_params.svh"
module i2c_bus_controller_timing (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       fast_mode_i,
  input  wire logic [7:0] period_i,
  input  wire logic       use_period_i,
  input  wire logic       go_i,
  input  wire logic [7:0] byte_i,
  output logic            busy_o,
  output logic            done_o,
  output logic            scl_o,
  output logic            scl_oe_o,
  output logic            sda_o,
  output logic            sda_oe_o
);

  // ----------------------------------------------------------------
  // Period selection
  // ----------------------------------------------------------------
  // Phase counts are wider than the port so the slow default fits
  wire logic [9:0] speed_period = fast_mode_i ? `PERIOD_FAST : `PERIOD_STD;
  wire logic [9:0] req_period   = use_period_i ? {2'b00, period_i} : speed_period;
  // Clamp below the minimum so the phases never collapse
  wire logic [9:0] eff_period   = (req_period < `PERIOD_MIN) ? `PERIOD_MIN : req_period;

  i2c_timing_pkg::ctl_state_t state_reg, state_next;
  logic [9:0] cnt_reg, cnt_next;
  logic [9:0] period_reg, period_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bit_reg, bit_next;
  logic       scl_low_reg, scl_low_next;
  logic       sda_low_reg, sda_low_next;
  logic       done_reg, done_next;
  logic       busy_reg;

  wire logic       cnt_end     = (cnt_reg == `CNT_ONE);
  wire logic [9:0] cnt_dec     = cnt_reg - `CNT_ONE;
  wire logic [9:0] half_period = {1'b0, period_reg[9:1]};
  wire logic       at_mid      = (cnt_reg == half_period);
  wire logic       busy_next   = (state_next != i2c_timing_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_dec;
    period_next  = period_reg;
    shift_next   = shift_reg;
    bit_next     = bit_reg;
    scl_low_next = scl_low_reg;
    sda_low_next = sda_low_reg;
    done_next    = 1'b0;
    case (state_reg)
      i2c_timing_pkg::ST_IDLE: begin
        cnt_next     = `CNT_ZERO;
        scl_low_next = 1'b0;
        sda_low_next = 1'b0;
        if (go_i) begin
          period_next = eff_period;
          shift_next  = byte_i;
          bit_next    = `BIT_LAST;
          cnt_next    = `START_SETUP_INTERVAL;
          state_next  = i2c_timing_pkg::ST_START_SETUP;
        end
      end
      i2c_timing_pkg::ST_START_SETUP: begin
        if (cnt_end) begin
          sda_low_next = 1'b1;
          cnt_next     = period_reg;
          state_next   = i2c_timing_pkg::ST_START_HOLD;
        end
      end
      i2c_timing_pkg::ST_START_HOLD: begin
        if (cnt_end) begin
          scl_low_next = 1'b1;
          cnt_next     = period_reg;
          state_next   = i2c_timing_pkg::ST_LOW;
        end
      end
      i2c_timing_pkg::ST_LOW: begin
        // Data moves at mid low phase, clear of both edges
        if (at_mid) begin
          sda_low_next = ~shift_reg[7];
        end
        if (cnt_end) begin
          scl_low_next = 1'b0;
          cnt_next     = period_reg;
          state_next   = i2c_timing_pkg::ST_HIGH;
        end
      end
      i2c_timing_pkg::ST_HIGH: begin
        if (cnt_end) begin
          scl_low_next = 1'b1;
          cnt_next     = period_reg;
          shift_next   = {shift_reg[6:0], 1'b0};
          if (bit_reg == `BIT_FIRST) begin
            state_next = i2c_timing_pkg::ST_STOP_LOW;
          end else begin
            bit_next   = bit_reg - `BIT_STEP;
            state_next = i2c_timing_pkg::ST_LOW;
          end
        end
      end
      i2c_timing_pkg::ST_STOP_LOW: begin
        if (at_mid) begin
          sda_low_next = 1'b1;
        end
        if (cnt_end) begin
          scl_low_next = 1'b0;
          cnt_next     = `STOP_SETUP_INTERVAL;
          state_next   = i2c_timing_pkg::ST_STOP_SETUP;
        end
      end
      i2c_timing_pkg::ST_STOP_SETUP: begin
        if (cnt_end) begin
          sda_low_next = 1'b0;
          done_next    = 1'b1;
          cnt_next     = `CNT_ZERO;
          state_next   = i2c_timing_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = i2c_timing_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg   <= i2c_timing_pkg::ST_IDLE;
      cnt_reg     <= `CNT_ZERO;
      period_reg  <= `PERIOD_STD;
      shift_reg   <= `SHIFT_RESET;
      bit_reg     <= `BIT_FIRST;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      done_reg    <= 1'b0;
      busy_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      period_reg  <= period_next;
      shift_reg   <= shift_next;
      bit_reg     <= bit_next;
      scl_low_reg <= scl_low_next;
      sda_low_reg <= sda_low_next;
      done_reg    <= done_next;
      busy_reg    <= busy_next;
    end
  end

  // ----------------------------------------------------------------
  // Open-drain pins
  // ----------------------------------------------------------------
  // Pin data is always low; a high level is only ever a released line
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = scl_low_reg;
  assign sda_oe_o = sda_low_reg;
  assign busy_o   = busy_reg;
  assign done_o   = done_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence start_setup_s;
    (!scl_oe_o && !sda_oe_o) [*8];
  endsequence

  sequence stop_hold_s;
    (sda_oe_o && !scl_oe_o) [*8];
  endsequence

  start_setup_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(sda_oe_o) && !scl_oe_o && state_reg == i2c_timing_pkg::ST_START_HOLD
      |-> $past(state_reg, 36) == i2c_timing_pkg::ST_START_SETUP
          && $past(state_reg, 37) == i2c_timing_pkg::ST_IDLE)
    else $error("start setup not 36 cycles");

  start_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(busy_o) |-> start_setup_s)
    else $error("lines not released before start");

  stop_setup_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(scl_oe_o == 1'b0) && state_reg == i2c_timing_pkg::ST_STOP_SETUP
      |-> stop_hold_s ##17 $fell(sda_oe_o))
    else $error("stop setup not 24 cycles");

  pin_low_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !scl_o && !sda_o)
    else $error("pin driven high");

  data_stable_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !scl_oe_o && $past(!scl_oe_o) && busy_o && state_reg == i2c_timing_pkg::ST_HIGH
      |-> $stable(sda_oe_o))
    else $error("data moved while clock high");

  high_time_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_reg == i2c_timing_pkg::ST_HIGH && $past(state_reg) == i2c_timing_pkg::ST_LOW
      |-> cnt_reg == period_reg)
    else $error("high time not from period");

  low_time_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_reg == i2c_timing_pkg::ST_LOW && $past(state_reg) != i2c_timing_pkg::ST_LOW
      |-> cnt_reg == period_reg && scl_oe_o)
    else $error("low time not from period");

  min_period_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    busy_o |-> period_reg >= `PERIOD_MIN)
    else $error("period below minimum");

  speed_sel_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    go_i && !busy_o && !use_period_i
      |=> period_reg == (($past(fast_mode_i)) ? `PERIOD_FAST : `PERIOD_STD))
    else $error("speed period wrong");

  done_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    done_o |-> !busy_o ##1 !done_o)
    else $error("done not one cycle");

endmodule

/* pkg/i2c_timing_params.svh */
`ifndef I2C_TIMING_PARAMS_SVH
`define I2C_TIMING_PARAMS_SVH
// Start and stop setup intervals, in system clock cycles
`define START_SETUP_INTERVAL 10'h024
`define STOP_SETUP_INTERVAL  10'h018
// Smallest permitted clock period setting
`define PERIOD_MIN           10'h004
// Phase lengths at 200 MHz: 2000 and 500 cycles per bit
`define PERIOD_STD           10'h3E8
`define PERIOD_FAST          10'h0FA
`define BIT_LAST             3'h7
`define BIT_FIRST            3'h0
`define BIT_STEP             3'h1
`define SHIFT_RESET          8'h00
`define CNT_ONE              10'h001
`define CNT_ZERO             10'h000
`endif

/* pkg/i2c_timing_pkg.sv */
package i2c_timing_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START_SETUP,
    ST_START_HOLD,
    ST_LOW,
    ST_HIGH,
    ST_STOP_LOW,
    ST_STOP_SETUP
  } ctl_state_t;
endpackage

/* sim/i2c_target_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Listening bus target
// ----------------------------------------
module i2c_target_model (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic      [7:0] rx_byte_o = 8'h00,
  output logic      [3:0] nbits_o = 4'h0
);
  // Never pulls either line, so both rest at the pullup level
  always @(negedge sda_i) begin
    if (scl_i) begin
      nbits_o = 4'h0;
    end
  end
  always @(posedge scl_i) begin
    // Only the first eight clocks after a start carry data
    if (nbits_o < 4'h8) begin
      rx_byte_o = {rx_byte_o[6:0], sda_i};
      nbits_o = nbits_o + 4'h1;
    end
  end
endmodule

/* sim/i2c_bus_controller_timing_tb_top.sv */
`timescale 1ns/100ps
`include "i2c_timing_params.svh"
module i2c_bus_controller_timing_tb_top;
  logic       clk_sys_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       fast = 1'b0;
  logic       use_p = 1'b0;
  logic [7:0] per = 8'h00;
  logic       go = 1'b0;
  logic [7:0] byte_v = 8'h00;
  logic       busy, done, scl_o, scl_oe, sda_o, sda_oe;
  logic [7:0] rx;
  logic [3:0] nb;
  int         failures = 0;
  int         num_checks = 0;
  // Pullup on both lines: low only while someone enables a driver
  wire        scl_w = scl_oe ? scl_o : 1'b1;
  wire        sda_w = sda_oe ? sda_o : 1'b1;
  always #2.5 clk_sys_i = ~clk_sys_i;
  i2c_bus_controller_timing uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .fast_mode_i(fast),
    .period_i(per), .use_period_i(use_p), .go_i(go), .byte_i(byte_v), .busy_o(busy),
    .done_o(done), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_o(sda_o), .sda_oe_o(sda_oe));
  i2c_target_model tgt (.scl_i(scl_w), .sda_i(sda_w), .rx_byte_o(rx), .nbits_o(nb));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Every SCL phase inside the frame must last exactly exp_p cycles
  task automatic run(input logic f, u, input logic [7:0] p, b, input logic re,
                     input logic [9:0] exp_p);
    int n, r, bad, chg, st, sp, dn, mv;
    logic ps, sf, pd;
    {r, bad, chg, st, sp, dn, mv, sf} = '0;
    ps = 1'b1;
    pd = 1'b1;
    @(negedge clk_sys_i);
    {fast, use_p, per, byte_v, go} = {f, u, p, b, 1'b1};
    for (n = 0; n < 20000 && dn == 0; n++) begin
      @(negedge clk_sys_i);
      go = re && n == 100;
      byte_v = re ? ~b : b;
      if ((scl_oe && scl_o !== 1'b0) || (sda_oe && sda_o !== 1'b0)) bad++;
      if (sda_w !== 1'b1) sf = 1'b1;
      if (!sf) st++;
      // Data may only move while SCL is low, outside start and stop
      if (scl_w && ps && sda_w !== pd && chg > 0 && chg < 18) mv++;
      if (scl_w !== ps) begin
        if (chg > 0 && r != exp_p) bad++;
        chg++;
        r = 0;
      end
      r++;
      ps = scl_w;
      pd = sda_w;
      if (chg == 18 && scl_w && !sda_w) sp++;
      if (done === 1'b1) dn++;
    end
    if (dn == 0) begin
      check(dn, 1);
      close_out();
    end
    repeat (2) @(negedge clk_sys_i);
    check(rx, b);
    check(nb, 4'h8);
    check(mv, 0);
    check(bad, 0);
    check(chg, 18);
    check(st >= 36, 1);
    check(sp >= 24, 1);
    check(busy, 1'b0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_fast(); run(1'b1, 1'b0, 8'h00, 8'hA5, 1'b0, `PERIOD_FAST); endtask
  task automatic t_std(); run(1'b0, 1'b0, 8'h00, 8'h3C, 1'b0, `PERIOD_STD); endtask
  task automatic t_min(); run(1'b1, 1'b1, 8'h04, 8'h81, 1'b0, `PERIOD_MIN); endtask
  // Below the minimum is clamped; a go while busy must be ignored
  task automatic t_clamp(); run(1'b0, 1'b1, 8'h01, 8'h7E, 1'b1, `PERIOD_MIN); endtask
  task automatic t_prog(); run(1'b1, 1'b1, 8'h09, 8'hFF, 1'b0, 10'h009); endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    t_fast();
    t_std();
    t_min();
    t_clamp();
    t_prog();
    close_out();
  end
endmodule
